// ---- include/odt_pkg.sv ----
// Package with opcodes, flag positions, cycle counts and bus map of the decode tail core
package odt_pkg;
	localparam logic [7:0] OP_TEST = 8'h00;
	localparam logic [7:0] OP_FLAGS_FROM_ACC = 8'h06;
	localparam logic [7:0] OP_FLAGS_TO_ACC = 8'h07;
	localparam logic [7:0] OP_PAGE_SECOND = 8'h18;
	localparam logic [7:0] OP_PAGE_MIXED_A = 8'h1A;
	localparam logic [7:0] OP_PAGE_MIXED_B = 8'hCD;
	localparam logic [7:0] OP_SP_TO_INDEX = 8'h30;
	localparam logic [7:0] OP_INDEX_TO_SP = 8'h35;
	localparam logic [7:0] OP_WAIT_FOR_IRQ = 8'h3E;
	localparam logic [7:0] OP_CHECK_ACC_HI = 8'h4D;
	localparam logic [7:0] OP_CHECK_ACC_LO = 8'h5D;
	localparam logic [7:0] OP_CHECK_MEM_ABS = 8'h7D;
	localparam logic [7:0] OP_SBC_LIT = 8'h82;
	localparam logic [7:0] OP_SBC_DIR = 8'h92;
	localparam logic [7:0] OP_SBC_ABS = 8'hB2;
	localparam logic [7:0] OP_SUB_DOUBLE_ACC_LIT = 8'h83;
	localparam logic [7:0] OP_SUB_DOUBLE_ACC_DIR = 8'h93;
	localparam logic [7:0] OP_SUB_DOUBLE_ACC_ABS = 8'hB3;
	localparam logic [7:0] OP_STD_DIR = 8'hDD;
	localparam logic [7:0] OP_STD_ABS = 8'hFD;
	localparam logic [7:0] OP_STD_IDX = 8'hED;
	// Flag bit positions: S X H I N Z V C
	localparam int FLAG_S = 7;
	localparam int FLAG_X = 6;
	localparam int FLAG_H = 5;
	localparam int FLAG_I = 4;
	localparam int FLAG_N = 3;
	localparam int FLAG_Z = 2;
	localparam int FLAG_V = 1;
	localparam int FLAG_C = 0;
	localparam logic [7:0] FLAGS_RESET = 8'hD0;
	localparam logic [7:0] DIRECT_PAGE = 8'h00;
	// Bus cycles per instruction
	localparam int CYC_TRANSFER = 2;
	localparam int CYC_SP_INDEX = 3;
	localparam int CYC_PREFIX_EXTRA = 1;
	localparam int CYC_WAIT_STACK = 12;
	localparam int CYC_WAIT_VECTOR = 2;
	// Clock and bus cycle rate
	localparam int CLK_HZ = 25000000;
	localparam int ECLK_HZ = 2000000;
	localparam int ECLK_DIV = CLK_HZ / ECLK_HZ;
	// AXI4-Lite map
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_ACC = 8'h08;
	localparam logic [7:0] ADDR_INDEX = 8'h0C;
	localparam logic [7:0] ADDR_PC_SP = 8'h10;
	localparam int CTRL_RUN = 0;
	localparam int CTRL_TEST_MODE = 1;
	localparam int CTRL_IRQ = 2;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum {ST_FETCH, ST_PAGE, ST_OPER_HI, ST_OPER_LO, ST_READ_HI, ST_READ_LO,
		ST_WRITE_HI, ST_WRITE_LO, ST_IDLE_CYC, ST_WAIT_STACK, ST_WAIT_HOLD,
		ST_WAIT_VECT, ST_TEST_COUNT, ST_HALT} odt_state_t;
	typedef enum {AM_NONE, AM_LIT8, AM_LIT16, AM_DIR, AM_ABS, AM_IDX} odt_mode_t;
endpackage

// ---- include/odt_mem_if.sv ----
// Memory-side signals of the core grouped for the bus port module
`timescale 1ns/10ps
interface odt_mem_if;
	logic [15:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic wr;
	logic step;
	modport core (output addr, output wdata, output wr, input rdata, input step);
	modport port (input addr, input wdata, input wr, output rdata, output step);
endinterface

// ---- core/odt_bus_port.sv ----
// Bus cycle divider and registered memory port
`timescale 1ns/10ps
module odt_bus_port #(
	parameter int DIV = odt_pkg::ECLK_DIV
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Core side
	odt_mem_if.port mem,
	// Memory pins
	output logic [15:0] memAddr,
	output logic [7:0] memWdata,
	output logic memWe,
	input wire logic [7:0] memRdata
);
	import odt_pkg::*;
	logic [7:0] divCnt_r, divCnt_nxt;
	logic [15:0] addr_r, addr_nxt;
	logic [7:0] wdata_r, wdata_nxt;
	logic we_r, we_nxt;
	always_comb begin
		divCnt_nxt = (divCnt_r == 8'(DIV - 1)) ? 8'h00 : divCnt_r + 8'h01;
		addr_nxt = mem.addr;
		wdata_nxt = mem.wdata;
		we_nxt = mem.wr;
	end
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			divCnt_r <= 8'h00;
			addr_r <= 16'h0000;
			wdata_r <= 8'h00;
			we_r <= 1'b0;
		end else begin
			divCnt_r <= divCnt_nxt;
			addr_r <= addr_nxt;
			wdata_r <= wdata_nxt;
			we_r <= we_nxt;
		end
	end
	// Memory is on the same clock, so its data needs no synchroniser
	assign mem.step = (divCnt_r == 8'(DIV - 1));
	assign mem.rdata = memRdata;
	assign memAddr = addr_r;
	assign memWdata = wdata_r;
	assign memWe = we_r & mem.step;
endmodule // odt_bus_port

// ---- core/odt_axil_regs.sv ----
// AXI4-Lite slave with control and state registers
`timescale 1ns/10ps
module odt_axil_regs (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// AXI4-Lite
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Core state
	output logic [7:0] control,
	input wire logic [31:0] statusWord,
	input wire logic [31:0] accWord,
	input wire logic [31:0] indexWord,
	input wire logic [31:0] pcSpWord
);
	import odt_pkg::*;
	logic [7:0] ctrl_r, ctrl_nxt;
	logic awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt, bValid_r, bValid_nxt;
	logic [7:0] awAddr_r, awAddr_nxt;
	logic [31:0] wData_r, wData_nxt;
	logic [3:0] wStrb_r, wStrb_nxt;
	logic [1:0] bResp_r, bResp_nxt, rResp_r, rResp_nxt;
	logic rValid_r, rValid_nxt;
	logic [31:0] rData_r, rData_nxt;
	always_comb begin
		awHeld_nxt = awHeld_r;
		wHeld_nxt = wHeld_r;
		awAddr_nxt = awAddr_r;
		wData_nxt = wData_r;
		wStrb_nxt = wStrb_r;
		bValid_nxt = bValid_r;
		bResp_nxt = bResp_r;
		ctrl_nxt = ctrl_r;
		rValid_nxt = rValid_r;
		rData_nxt = rData_r;
		rResp_nxt = rResp_r;
		if (s_axi_awvalid && s_axi_awready) begin
			awHeld_nxt = 1'b1;
			awAddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wHeld_nxt = 1'b1;
			wData_nxt = s_axi_wdata;
			wStrb_nxt = s_axi_wstrb;
		end
		if (awHeld_r && wHeld_r && !bValid_r) begin
			awHeld_nxt = 1'b0;
			wHeld_nxt = 1'b0;
			bValid_nxt = 1'b1;
			bResp_nxt = RESP_OKAY;
			if (awAddr_r == ADDR_CONTROL) begin
				if (wStrb_r[0])
					ctrl_nxt = wData_r[7:0];
			end else
				bResp_nxt = RESP_SLVERR;
		end
		if (bValid_r && s_axi_bready)
			bValid_nxt = 1'b0;
		if (s_axi_arvalid && s_axi_arready) begin
			rValid_nxt = 1'b1;
			rResp_nxt = RESP_OKAY;
			case (s_axi_araddr)
				ADDR_CONTROL: rData_nxt = {24'h000000, ctrl_r};
				ADDR_STATUS: rData_nxt = statusWord;
				ADDR_ACC: rData_nxt = accWord;
				ADDR_INDEX: rData_nxt = indexWord;
				ADDR_PC_SP: rData_nxt = pcSpWord;
				default: begin
					rData_nxt = 32'h00000000;
					rResp_nxt = RESP_SLVERR;
				end
			endcase
		end else if (rValid_r && s_axi_rready)
			rValid_nxt = 1'b0;
	end
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			ctrl_r <= 8'h00;
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			awAddr_r <= 8'h00;
			wData_r <= 32'h00000000;
			wStrb_r <= 4'h0;
			bValid_r <= 1'b0;
			bResp_r <= RESP_OKAY;
			rValid_r <= 1'b0;
			rData_r <= 32'h00000000;
			rResp_r <= RESP_OKAY;
		end else begin
			ctrl_r <= ctrl_nxt;
			awHeld_r <= awHeld_nxt;
			wHeld_r <= wHeld_nxt;
			awAddr_r <= awAddr_nxt;
			wData_r <= wData_nxt;
			wStrb_r <= wStrb_nxt;
			bValid_r <= bValid_nxt;
			bResp_r <= bResp_nxt;
			rValid_r <= rValid_nxt;
			rData_r <= rData_nxt;
			rResp_r <= rResp_nxt;
		end
	end
	assign s_axi_awready = !awHeld_r;
	assign s_axi_wready = !wHeld_r;
	assign s_axi_bvalid = bValid_r;
	assign s_axi_bresp = bResp_r;
	assign s_axi_arready = !rValid_r;
	assign s_axi_rvalid = rValid_r;
	assign s_axi_rdata = rData_r;
	assign s_axi_rresp = rResp_r;
	assign control = ctrl_r;
endmodule // odt_axil_regs

// ---- core/odt_decode_core.sv ----
// Instruction decode and execute core for the tail of the opcode map
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
// Overview of operation
// - Double store writes high accumulator then low; N Z updated, V cleared, C kept.
// - Subtract with carry: high acc minus memory minus carry, N Z V C updated.
// - Flags from high acc in 2 cycles; X mask may be cleared, never set.
// - Zero or minus check writes nothing; N Z updated, V C cleared.
// - Stack pointer plus one into first index, 3 cycles; second form 4 cycles.
// - First index minus one into stack pointer, 3 cycles, flags unchanged.
// - Second index to stack pointer uses prefix 18 and takes 4 cycles.
// - Flags to high accumulator in 2 cycles, flags unchanged.
// - Wait: 12 stacking cycles, hold until interrupt, then 2 vector cycles.
// - Test opcode 00 makes the address bus count until reset.
// - Direct address is the operand byte with high byte zero.
// - Indexed offset is unsigned 0 to 255 added to the index register.
// - Absolute address fetched high byte first, then low byte.
// - 16-bit literal fetched high byte first, then low byte.
// - Relative offset is signed and added to the following address.
// - A down-arrow flag can be cleared but never set.
// - A delta flag follows the operation result.
module odt_decode_core (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// AXI4-Lite register port
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Program and data memory
	output logic [15:0] memAddr,
	output logic [7:0] memWdata,
	output logic memWe,
	input wire logic [7:0] memRdata
);
	import odt_pkg::*;
	odt_mem_if mem();
	logic [7:0] control;
	logic [31:0] statusWord, accWord, indexWord, pcSpWord;
	odt_state_t st_r, st_nxt;
	odt_mode_t mode_r, mode_nxt;
	logic [7:0] op_r, op_nxt, page_r, page_nxt, flags_r, flags_nxt;
	logic [7:0] accHi_r, accHi_nxt, accLo_r, accLo_nxt;
	logic [15:0] idxA_r, idxA_nxt, idxB_r, idxB_nxt, sp_r, sp_nxt, pc_r, pc_nxt;
	logic [15:0] ea_r, ea_nxt, opnd_r, opnd_nxt, busAddr_r, busAddr_nxt;
	logic [7:0] wdata_r, wdata_nxt;
	logic wr_r, wr_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [16:0] diff;
	logic [8:0] diff8;
	logic [15:0] relTarget;
	logic irqSync1_r, irqSync2_r;

	odt_bus_port u_port (
		.clock(clock),
		.rst_b(rst_b),
		.mem(mem.port),
		.memAddr(memAddr),
		.memWdata(memWdata),
		.memWe(memWe),
		.memRdata(memRdata)
	);
	odt_axil_regs u_regs (
		.clock(clock), .rst_b(rst_b),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.control(control), .statusWord(statusWord), .accWord(accWord),
		.indexWord(indexWord), .pcSpWord(pcSpWord)
	);

	// Addressing mode from the low opcode column
	function automatic odt_mode_t modeOf(input logic [7:0] op);
		case (op[5:4])
			2'b00: modeOf = (op[3:0] == 4'h3) ? AM_LIT16 : AM_LIT8;
			2'b01: modeOf = AM_DIR;
			2'b10: modeOf = AM_IDX;
			default: modeOf = AM_ABS;
		endcase
	endfunction

	// N and Z from a byte
	function automatic logic [1:0] nz8(input logic [7:0] v);
		nz8 = {v[7], v == 8'h00};
	endfunction

	// Relative target, kept for branch users of this decoder
	assign relTarget = pc_r + {{8{opnd_r[7]}}, opnd_r[7:0]};
	assign diff = {1'b0, accHi_r, accLo_r} - {1'b0, opnd_r};
	assign diff8 = {1'b0, accHi_r} - {1'b0, opnd_r[7:0]} - {8'h00, flags_r[FLAG_C]};

	// Interrupt request bit comes from software, still synchronised as a pin would be
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			irqSync1_r <= 1'b0;
			irqSync2_r <= 1'b0;
		end else begin
			irqSync1_r <= control[CTRL_IRQ];
			irqSync2_r <= irqSync1_r;
		end
	end

	always_comb begin
		st_nxt = st_r; mode_nxt = mode_r; op_nxt = op_r; page_nxt = page_r;
		flags_nxt = flags_r; accHi_nxt = accHi_r; accLo_nxt = accLo_r;
		idxA_nxt = idxA_r; idxB_nxt = idxB_r; sp_nxt = sp_r; pc_nxt = pc_r;
		ea_nxt = ea_r; opnd_nxt = opnd_r; busAddr_nxt = busAddr_r;
		wdata_nxt = wdata_r; wr_nxt = 1'b0; cnt_nxt = cnt_r;
		if (mem.step) begin
			case (st_r)
				ST_HALT: begin
					if (control[CTRL_RUN]) begin
						st_nxt = ST_FETCH;
						busAddr_nxt = pc_r;
					end
				end
				ST_FETCH, ST_PAGE: begin
					pc_nxt = pc_r + 16'h0001;
					busAddr_nxt = pc_r + 16'h0001;
					if (st_r == ST_FETCH && (mem.rdata == OP_PAGE_SECOND
						|| mem.rdata == OP_PAGE_MIXED_A || mem.rdata == OP_PAGE_MIXED_B)) begin
						page_nxt = mem.rdata;
						st_nxt = ST_PAGE;
					end else begin
						if (st_r == ST_FETCH)
							page_nxt = 8'h00;
						op_nxt = mem.rdata;
						mode_nxt = modeOf(mem.rdata);
						cnt_nxt = 4'h0;
						st_nxt = ST_IDLE_CYC;
						case (mem.rdata)
							OP_TEST: if (control[CTRL_TEST_MODE]) st_nxt = ST_TEST_COUNT;
							OP_WAIT_FOR_IRQ: st_nxt = ST_WAIT_STACK;
							OP_SBC_LIT, OP_SBC_DIR, OP_SBC_ABS, OP_SUB_DOUBLE_ACC_LIT, OP_SUB_DOUBLE_ACC_DIR,
							OP_SUB_DOUBLE_ACC_ABS, OP_STD_DIR, OP_STD_ABS, OP_STD_IDX, OP_CHECK_MEM_ABS:
								st_nxt = ST_OPER_HI;
							default: st_nxt = ST_IDLE_CYC;
						endcase
					end
				end
				ST_OPER_HI: begin
					pc_nxt = pc_r + 16'h0001;
					busAddr_nxt = pc_r + 16'h0001;
					opnd_nxt = {8'h00, mem.rdata};
					case (mode_r)
						AM_DIR: begin
							ea_nxt = {DIRECT_PAGE, mem.rdata};
							busAddr_nxt = {DIRECT_PAGE, mem.rdata};
							st_nxt = ST_READ_HI;
						end
						AM_IDX: begin
							ea_nxt = (page_r == OP_PAGE_SECOND ? idxB_r : idxA_r)
								+ {8'h00, mem.rdata};
							busAddr_nxt = ea_nxt;
							st_nxt = ST_READ_HI;
						end
						AM_LIT8: st_nxt = ST_IDLE_CYC;
						default: st_nxt = ST_OPER_LO;
					endcase
					if (op_r[6] && (mode_r == AM_DIR || mode_r == AM_IDX)) begin
						st_nxt = ST_WRITE_HI;
						wdata_nxt = accHi_r;
						wr_nxt = 1'b1;
					end
				end
				ST_OPER_LO: begin
					pc_nxt = pc_r + 16'h0001;
					busAddr_nxt = pc_r + 16'h0001;
					opnd_nxt = {opnd_r[7:0], mem.rdata};
					if (mode_r == AM_ABS) begin
						ea_nxt = {opnd_r[7:0], mem.rdata};
						busAddr_nxt = {opnd_r[7:0], mem.rdata};
						st_nxt = ST_READ_HI;
						if (op_r == OP_STD_ABS) begin
							st_nxt = ST_WRITE_HI;
							wdata_nxt = accHi_r;
							wr_nxt = 1'b1;
						end
					end else
						st_nxt = ST_IDLE_CYC;
				end
				ST_READ_HI: begin
					opnd_nxt = {8'h00, mem.rdata};
					st_nxt = ST_IDLE_CYC;
					if (op_r[3:0] == 4'h3) begin
						busAddr_nxt = ea_r + 16'h0001;
						st_nxt = ST_READ_LO;
					end
				end
				ST_READ_LO: begin
					opnd_nxt = {opnd_r[7:0], mem.rdata};
					st_nxt = ST_IDLE_CYC;
				end
				ST_WRITE_HI: begin
					busAddr_nxt = ea_r + 16'h0001;
					wdata_nxt = accLo_r;
					wr_nxt = 1'b1;
					st_nxt = ST_WRITE_LO;
				end
				ST_WRITE_LO: begin
					flags_nxt[FLAG_N] = accHi_r[7];
					flags_nxt[FLAG_Z] = {accHi_r, accLo_r} == 16'h0000;
					flags_nxt[FLAG_V] = 1'b0;
					busAddr_nxt = pc_r;
					st_nxt = ST_FETCH;
				end
				ST_IDLE_CYC: begin
					// Execute in the last cycle; a prefix spent its extra cycle on the page fetch
					busAddr_nxt = pc_r;
					st_nxt = ST_FETCH;
					case (op_r)
						OP_FLAGS_FROM_ACC: begin
							flags_nxt = accHi_r;
							flags_nxt[FLAG_X] = accHi_r[FLAG_X] & flags_r[FLAG_X];
						end
						OP_FLAGS_TO_ACC: accHi_nxt = flags_r;
						OP_CHECK_ACC_HI, OP_CHECK_ACC_LO, OP_CHECK_MEM_ABS: begin
							flags_nxt[FLAG_N:FLAG_Z] = nz8(op_r == OP_CHECK_ACC_HI ? accHi_r
								: op_r == OP_CHECK_ACC_LO ? accLo_r : opnd_r[7:0]);
							flags_nxt[FLAG_V] = 1'b0;
							flags_nxt[FLAG_C] = 1'b0;
						end
						OP_SP_TO_INDEX, OP_INDEX_TO_SP: begin
							if (cnt_r < 4'(CYC_SP_INDEX - 2)) begin
								cnt_nxt = cnt_r + 4'h1;
								busAddr_nxt = busAddr_r;
								st_nxt = ST_IDLE_CYC;
							end else if (op_r == OP_SP_TO_INDEX) begin
								if (page_r == OP_PAGE_SECOND) idxB_nxt = sp_r + 16'h0001;
								else idxA_nxt = sp_r + 16'h0001;
							end else
								sp_nxt = (page_r == OP_PAGE_SECOND ? idxB_r : idxA_r)
									- 16'h0001;
						end
						OP_SBC_LIT, OP_SBC_DIR, OP_SBC_ABS: begin
							accHi_nxt = diff8[7:0];
							flags_nxt[FLAG_N:FLAG_Z] = nz8(diff8[7:0]);
							flags_nxt[FLAG_V] = (accHi_r[7] ^ opnd_r[7]) & (accHi_r[7] ^ diff8[7]);
							flags_nxt[FLAG_C] = diff8[8];
						end
						OP_SUB_DOUBLE_ACC_LIT, OP_SUB_DOUBLE_ACC_DIR, OP_SUB_DOUBLE_ACC_ABS: begin
							{accHi_nxt, accLo_nxt} = diff[15:0];
							flags_nxt[FLAG_N] = diff[15];
							flags_nxt[FLAG_Z] = diff[15:0] == 16'h0000;
							flags_nxt[FLAG_V] = (accHi_r[7] ^ opnd_r[15]) & (accHi_r[7] ^ diff[15]);
							flags_nxt[FLAG_C] = diff[16];
						end
						default: ;
					endcase
				end
				ST_WAIT_STACK: begin
					// Stack writes are modelled as bus idle cycles of fixed count
					cnt_nxt = cnt_r + 4'h1;
					if (cnt_r == 4'(CYC_WAIT_STACK - 2)) begin
						st_nxt = ST_WAIT_HOLD;
						cnt_nxt = 4'h0;
					end
				end
				ST_WAIT_HOLD: if (irqSync2_r) st_nxt = ST_WAIT_VECT;
				ST_WAIT_VECT: begin
					cnt_nxt = cnt_r + 4'h1;
					if (cnt_r == 4'(CYC_WAIT_VECTOR - 1)) begin
						st_nxt = ST_FETCH;
						busAddr_nxt = pc_r;
					end
				end
				ST_TEST_COUNT: busAddr_nxt = busAddr_r + 16'h0001;
				default: st_nxt = ST_HALT;
			endcase
		end else
			wr_nxt = wr_r;
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			st_r <= ST_HALT; mode_r <= AM_NONE; op_r <= 8'h00; page_r <= 8'h00;
			flags_r <= FLAGS_RESET; accHi_r <= 8'h00; accLo_r <= 8'h00;
			idxA_r <= 16'h0000; idxB_r <= 16'h0000; sp_r <= 16'h0000; pc_r <= 16'h0000;
			ea_r <= 16'h0000; opnd_r <= 16'h0000; busAddr_r <= 16'h0000;
			wdata_r <= 8'h00; wr_r <= 1'b0; cnt_r <= 4'h0;
		end else begin
			st_r <= st_nxt; mode_r <= mode_nxt; op_r <= op_nxt; page_r <= page_nxt;
			flags_r <= flags_nxt; accHi_r <= accHi_nxt; accLo_r <= accLo_nxt;
			idxA_r <= idxA_nxt; idxB_r <= idxB_nxt; sp_r <= sp_nxt; pc_r <= pc_nxt;
			ea_r <= ea_nxt; opnd_r <= opnd_nxt; busAddr_r <= busAddr_nxt;
			wdata_r <= wdata_nxt; wr_r <= wr_nxt; cnt_r <= cnt_nxt;
		end
	end

	assign mem.addr = busAddr_r;
	assign mem.wdata = wdata_r;
	assign mem.wr = wr_r;
	assign statusWord = {8'h00, relTarget[7:0], 4'h0, cnt_r, flags_r};
	assign accWord = {16'h0000, accHi_r, accLo_r};
	assign indexWord = {idxB_r, idxA_r};
	assign pcSpWord = {pc_r, sp_r};
endmodule // odt_decode_core

// ---- verif/odt_mem_model.sv ----
// Behavioural program and data memory with a log of every write
`timescale 1ns/10ps
module odt_mem_model (
	// Clock
	input wire logic clock,
	// Memory pins of the core
	input wire logic [15:0] memAddr,
	input wire logic [7:0] memWdata,
	input wire logic memWe,
	output logic [7:0] memRdata
);
	logic [7:0] mem [0:65535] = '{default: 8'h00};
	logic [23:0] wLog [$];
	int wTime [$];
	int cyc = 0;
	// Answered at once; the core samples on the last clock of a bus cycle
	assign memRdata = mem[memAddr];
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (memWe === 1'b1) begin
			mem[memAddr] <= memWdata;
			wLog.push_back({memAddr, memWdata});
			wTime.push_back(cyc);
		end
	end
endmodule // odt_mem_model

// ---- verif/odt_decode_core_properties.sv ----
// Port properties of the decode tail core
`timescale 1ns/10ps
module odt_core_properties (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Memory
	input wire logic [15:0] memAddr,
	input wire logic [7:0] memWdata,
	input wire logic memWe
);
	logic wrOdd_r;
	logic wrOdd_nxt;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	// Stores come in pairs, so parity marks the high byte
	always_comb wrOdd_nxt = memWe ? !wrOdd_r : wrOdd_r;
	always_ff @(posedge clock) wrOdd_r <= rst_b ? wrOdd_nxt : 1'b0;
	a_store_pair: assert property (memWe && !wrOdd_r |-> ##12 memWe &&
		memAddr == $past(memAddr, 12) + 16'h0001) else $error("low byte not at next address");
	a_we_pulse: assert property (memWe |=> !memWe) else $error("write strobe too long");
	a_addr_hold: assert property ($changed(memAddr) |=> $stable(memAddr) [*8])
		else $error("address changed within a bus cycle");
	a_wdata_hold: assert property (memWe |-> $stable(memWdata)) else $error("write data moved");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
		$stable(s_axi_bresp)) else $error("write response dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
		$stable(s_axi_rdata)) else $error("read data dropped");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
	a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
	a_reset_quiet: assert property (@(posedge clock) disable iff (1'b0) !rst_b |=>
		!memWe && !s_axi_bvalid && !s_axi_rvalid) else $error("outputs active in reset");
endmodule // odt_core_properties
bind odt_decode_core odt_core_properties chk_u (.clock(clock), .rst_b(rst_b),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.memAddr(memAddr), .memWdata(memWdata), .memWe(memWe));

// ---- verif/tb_top.sv ----
// Self-checking bench of the decode tail core
`timescale 1ns/10ps
module tb_top;
	import odt_pkg::*;
	localparam logic [7:0] PROG [0:39] = '{8'h82, 8'h01, 8'h82, 8'hBF, 8'h06, 8'h82, 8'hC0,
		8'h06, 8'h07, 8'h4D, 8'h83, 8'h00, 8'h3F, 8'hDD, 8'h80, 8'h30, 8'h18, 8'h35, 8'h18,
		8'h30, 8'h35, 8'hED, 8'hFF, 8'hFD, 8'h12, 8'h34, 8'h92, 8'h80, 8'hB2, 8'h12, 8'h35,
		8'h7D, 8'h01, 8'h01, 8'h93, 8'h80, 8'hB3, 8'h01, 8'h00, 8'h5D};
	// Rows: address, byte, bus cycles since the previous write
	localparam logic [31:0] WROWS [0:5] = '{32'h00803D00, 32'h0081C101, 32'h01003D11,
		32'h0101C101, 32'h12343D04, 32'h1235C101};
	// Rows: register, mask, expected value
	localparam logic [71:0] RROWS [0:3] = '{{8'h04, 32'h000000FF, 32'h00000030},
		{8'h08, 32'h0000FFFF, 32'h0000C43F}, {8'h0C, 32'hFFFFFFFF, 32'h00000001},
		{8'h10, 32'h0000FFFF, 32'h00000000}};
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, memWe;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [15:0] memAddr;
	logic [7:0] memWdata, memRdata;
	int n_fail = 0, checked = 0, cycles = 0;
	always #20 clock = ~clock;
	odt_decode_core dut_u (.clock(clock), .rst_b(rst_b), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.memAddr(memAddr), .memWdata(memWdata), .memWe(memWe), .memRdata(memRdata));
	odt_mem_model mem_u (.clock(clock), .memAddr(memAddr), .memWdata(memWdata),
		.memWe(memWe), .memRdata(memRdata));
	task automatic results;
		$display("Checks %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			@(posedge clock);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				done = 1'b1;
				bready <= 1'b0;
				check({30'h0, bresp}, {30'h0, er});
			end
		end
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic done;
		done = 1'b0;
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done) begin
			@(posedge clock);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				done = 1'b1;
				d = rdata;
				r = rresp;
				rready <= 1'b0;
			end
		end
	endtask
	// Later reset with a fresh first opcode
	task automatic rst(input logic [7:0] op);
		mem_u.mem[0] = op;
		rst_b <= 1'b0;
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
	endtask
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 10000) begin
			n_fail++;
			results();
		end
	end
	initial begin
		logic [31:0] d, d1;
		logic [1:0] r;
		logic [15:0] a0;
		for (int i = 0; i < 40; i++) mem_u.mem[i] = PROG[i];
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
		axr(ADDR_CONTROL, d, r);
		check(d, 32'h0);
		axw(ADDR_CONTROL, 32'h1, RESP_OKAY);
		repeat (90 * ECLK_DIV) @(posedge clock);
		check(mem_u.wLog.size(), 6);
		for (int i = 0; i < 6; i++) begin
			check({8'h0, mem_u.wLog[i]}, {8'h0, WROWS[i][31:8]});
			if (i > 0) check(mem_u.wTime[i] - mem_u.wTime[i - 1], WROWS[i][7:0] * ECLK_DIV);
		end
		for (int i = 0; i < 4; i++) begin
			axr(RROWS[i][71:64], d, r);
			check(d & RROWS[i][63:32], RROWS[i][31:0]);
		end
		// Unmapped places are refused both ways
		axr(8'h14, d, r);
		check({d[29:0], r}, {30'h0, RESP_SLVERR});
		axw(8'h20, 32'h1, RESP_SLVERR);
		rst(OP_WAIT_FOR_IRQ);
		axw(ADDR_CONTROL, 32'h1, RESP_OKAY);
		repeat (20 * ECLK_DIV) @(posedge clock);
		axr(ADDR_PC_SP, d1, r);
		repeat (10 * ECLK_DIV) @(posedge clock);
		axr(ADDR_PC_SP, d, r);
		check({16'h0, d[31:16]}, {16'h0, d1[31:16]});
		axw(ADDR_CONTROL, 32'h5, RESP_OKAY);
		repeat (10 * ECLK_DIV) @(posedge clock);
		axr(ADDR_PC_SP, d, r);
		check({31'h0, d[31:16] > d1[31:16]}, 32'h1);
		rst(OP_TEST);
		axw(ADDR_CONTROL, 32'h3, RESP_OKAY);
		for (int k = 0; k < 2; k++) begin
			repeat (4 * ECLK_DIV) @(posedge clock);
			#1 a0 = memAddr;
			repeat (10 * ECLK_DIV) @(posedge clock);
			#1 check({16'h0, memAddr}, {16'h0, a0 + 16'h000A});
			// Clearing the enable must not stop the count
			axw(ADDR_CONTROL, 32'h0, RESP_OKAY);
		end
		results();
	end
endmodule // tb_top
